// ==== rtl/wbl_pkg.sv ====
// package: constants, types and notes for the buffer-write / long-write command block
// Notes on behaviour
// - opcode 3Bh is buffer write; mode is low three bits of CDB byte 1
// - buffer id zero always exists; further buffers numbered contiguously from one
// - unsupported buffer id ends with check condition, illegal request, invalid field
// - data mode stores bytes into selected buffer starting at buffer offset
// - unacceptable offset ends with check condition, illegal request, invalid field
// - parameter list length bounds bytes accepted in data out
// - offset plus length beyond capacity ends with check condition, invalid field
// - mode 100b loads control memory; reset reverts to prior operation
// - download modes do not require id, offset and length to be zero
// - successful download raises microcode-changed unit attention for other initiators
// - mode 101b saves code to non-volatile store, effective after every reset
// - opcode 3Fh is long write: one block plus ecc bytes
// - long write cdb: block bytes 2..5 msb first, length 7..8, flag bit 0
// - byte transfer length equals sector size plus eleven ecc bytes
// - long write starts at the starting block number
// - physical position uses physical sector size, not logical block size
// - invalid starting block ends with check condition, illegal block address
package wbl_pkg;
  localparam logic [7:0] OP_BUF_WRITE = 8'h3b;
  localparam logic [7:0] OP_LONG_WRITE = 8'h3f;
  localparam logic [2:0] MODE_DATA = 3'h2;
  localparam logic [2:0] MODE_DL = 3'h4;
  localparam logic [2:0] MODE_DL_SAVE = 3'h5;
  localparam int ECC_BYTES = 11;
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [3:0] SK_UNIT_ATTN = 4'h6;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_BAD_BLOCK = 8'h21;
  localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
  localparam logic [7:0] ASC_UCODE_CHANGED = 8'h3f;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_SENSE = 8'h08;
  localparam logic [7:0] A_IRQ_STAT = 8'h0c;
  localparam logic [7:0] A_IRQ_MASK = 8'h10;
  localparam logic [7:0] A_MAX_BLOCK = 8'h14;
  localparam logic [7:0] A_UA_PEND = 8'h18;
  localparam logic [7:0] A_POS = 8'h1c;
  localparam logic [7:0] A_UCODE_REV = 8'h20;
  localparam logic [31:0] MAX_BLOCK_RST = 32'h0000ffff;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_CHECK = 1;
  localparam int IRQ_UCODE = 2;
  localparam int IRQ_BYTE = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
    logic [7:0] b6;
    logic [7:0] b7;
    logic [7:0] b8;
    logic [7:0] ctrl;
  } wbl_cdb_t;

  typedef struct packed {
    logic [7:0] status;
    logic [3:0] sense_key;
    logic [7:0] asc;
  } wbl_result_t;
endpackage : wbl_pkg

// ==== rtl/wbl_cmd.sv ====
// command interpreter for buffer write and long write, with axi4-lite registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module wbl_cmd import wbl_pkg::*; #(
  parameter int NUM_BUFS = 2,
  parameter int BUF_DEPTH = 256,
  parameter int OFFSET_ALIGN = 1,
  parameter int PHYS_SECTOR = 512,
  parameter int NUM_INIT = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // command from the bus front end
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire wbl_cdb_t cmd_cdb,
  input wire logic [2:0] cmd_initiator,
  // data out bytes
  input wire logic dout_valid,
  output logic dout_ready,
  input wire logic [7:0] dout_data,
  // completion
  output logic done_valid,
  output wbl_result_t done_result,
  output logic [31:0] xfer_count,
  // media write request for long write
  output logic media_req,
  output logic [31:0] media_byte_pos,
  output logic [15:0] media_len,
  input wire logic media_done,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);
  localparam int CAP_W = $clog2(BUF_DEPTH + 1);
  localparam int IDX_W = $clog2(NUM_BUFS * BUF_DEPTH);

  typedef enum {S_IDLE, S_DECODE, S_DATA, S_MEDIA, S_DONE} wbl_state_t;
  wbl_state_t state_reg;

  wbl_cdb_t cdb_reg;
  logic [2:0] init_reg;
  logic [23:0] remain_reg;
  logic [23:0] addr_reg;
  logic [7:0] bufid_reg;
  wbl_result_t result_reg;
  logic [31:0] count_reg;
  logic [7:0] ucode_mem [0:BUF_DEPTH-1];
  logic [7:0] data_mem [0:NUM_BUFS*BUF_DEPTH-1];
  logic [7:0] ucode_rev_reg;
  // power-up contents of the non-volatile store; deliberately never reset
  logic [7:0] ucode_saved_reg = 8'h00;
  logic [NUM_INIT-1:0] ua_pend_reg;
  logic [31:0] max_block_reg;
  logic enable_reg;
  logic [7:0] irq_stat_reg;
  logic [7:0] irq_mask_reg;
  logic [31:0] pos_reg;

  // cdb field views
  wire logic [2:0] mode = cdb_reg.b1[2:0];
  wire logic [23:0] buf_off = {cdb_reg.b3, cdb_reg.b4, cdb_reg.b5};
  wire logic [23:0] plen = {cdb_reg.b6, cdb_reg.b7, cdb_reg.b8};
  wire logic [31:0] start_block = {cdb_reg.b2, cdb_reg.b3, cdb_reg.b4, cdb_reg.b5};
  wire logic [15:0] long_len = {cdb_reg.b7, cdb_reg.b8};
  wire logic relative_address_flag = cdb_reg.b1[0];
  wire logic [24:0] end_off = {1'b0, buf_off} + {1'b0, plen};

  wire logic byte_take = dout_valid && dout_ready;
  assign cmd_ready = (state_reg == S_IDLE) && enable_reg;
  assign dout_ready = (state_reg == S_DATA) && (remain_reg != 24'h0);
  assign done_valid = (state_reg == S_DONE);
  assign done_result = result_reg;
  assign xfer_count = count_reg;
  assign media_req = (state_reg == S_MEDIA);
  assign media_len = long_len;
  assign media_byte_pos = pos_reg;

  function automatic wbl_result_t mk_res(input logic [7:0] st, input logic [3:0] sk, input logic [7:0] asc);
    wbl_result_t r;
    r.status = st;
    r.sense_key = sk;
    r.asc = asc;
    return r;
  endfunction : mk_res

  // command sequencing
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      cdb_reg <= '0;
      init_reg <= 3'h0;
      remain_reg <= 24'h0;
      addr_reg <= 24'h0;
      bufid_reg <= 8'h0;
      result_reg <= '0;
      count_reg <= 32'h0;
      pos_reg <= 32'h0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cdb_reg <= cmd_cdb;
            init_reg <= cmd_initiator;
            count_reg <= 32'h0;
            state_reg <= S_DECODE;
          end
        end
        S_DECODE: begin
          result_reg <= mk_res(ST_GOOD, SK_NONE, ASC_NONE);
          bufid_reg <= cdb_reg.b2;
          addr_reg <= buf_off;
          remain_reg <= plen;
          state_reg <= S_DATA;
          if (cdb_reg.opcode == OP_BUF_WRITE) begin
            if (mode == MODE_DATA) begin
              if (cdb_reg.b2 >= 8'(NUM_BUFS)) begin
                result_reg <= mk_res(ST_CHECK, SK_ILLEGAL, ASC_BAD_FIELD);
                state_reg <= S_DONE;
              end else if ((buf_off % 24'(OFFSET_ALIGN)) != 24'h0 || buf_off >= 24'(BUF_DEPTH)) begin
                result_reg <= mk_res(ST_CHECK, SK_ILLEGAL, ASC_BAD_FIELD);
                state_reg <= S_DONE;
              end else if (end_off > 25'(BUF_DEPTH)) begin
                result_reg <= mk_res(ST_CHECK, SK_ILLEGAL, ASC_BAD_FIELD);
                state_reg <= S_DONE;
              end
            end else if (mode == MODE_DL || mode == MODE_DL_SAVE) begin
              // id and offset are ignored; length bounds the image, capped at BUF_DEPTH
              addr_reg <= 24'h0;
              if (plen > 24'(BUF_DEPTH)) begin
                remain_reg <= 24'(BUF_DEPTH);
              end
            end else begin
              result_reg <= mk_res(ST_CHECK, SK_ILLEGAL, ASC_BAD_FIELD);
              state_reg <= S_DONE;
            end
          end else if (cdb_reg.opcode == OP_LONG_WRITE) begin
            remain_reg <= 24'(long_len);
            // relative addressing not supported: treat a set flag as an illegal field
            if (relative_address_flag || cdb_reg.b6 != 8'h0 ||
                long_len != 16'(PHYS_SECTOR + ECC_BYTES)) begin
              result_reg <= mk_res(ST_CHECK, SK_ILLEGAL, ASC_BAD_FIELD);
              state_reg <= S_DONE;
            end else if (start_block > max_block_reg) begin
              result_reg <= mk_res(ST_CHECK, SK_ILLEGAL, ASC_BAD_BLOCK);
              state_reg <= S_DONE;
            end else begin
              pos_reg <= 32'(start_block * 32'(PHYS_SECTOR));
            end
          end else begin
            result_reg <= mk_res(ST_CHECK, SK_ILLEGAL, ASC_BAD_FIELD);
            state_reg <= S_DONE;
          end
        end
        S_DATA: begin
          if (byte_take) begin
            remain_reg <= remain_reg - 24'h1;
            addr_reg <= addr_reg + 24'h1;
            count_reg <= count_reg + 32'h1;
          end
          if (remain_reg == 24'h0 || (byte_take && remain_reg == 24'h1)) begin
            state_reg <= (cdb_reg.opcode == OP_LONG_WRITE) ? S_MEDIA : S_DONE;
          end
        end
        S_MEDIA: begin
          if (media_done) begin
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // buffer and control-memory storage
  always_ff @(posedge clk_sys) begin
    if (byte_take && cdb_reg.opcode == OP_BUF_WRITE && mode == MODE_DATA) begin
      data_mem[IDX_W'(bufid_reg) * IDX_W'(BUF_DEPTH) + IDX_W'(addr_reg)] <= dout_data;
    end
    if (byte_take && cdb_reg.opcode == OP_BUF_WRITE && (mode == MODE_DL || mode == MODE_DL_SAVE)) begin
      ucode_mem[addr_reg[CAP_W-2:0]] <= dout_data;
    end
  end

  wire logic cmd_ok_done = (state_reg == S_DONE) && (result_reg.status == ST_GOOD);
  wire logic dl_ok = cmd_ok_done && cdb_reg.opcode == OP_BUF_WRITE && (mode == MODE_DL || mode == MODE_DL_SAVE);

  // microcode revision: a flag, not a copy, selects the saved image after reset,
  // so the reset branch stays constant
  logic ucode_live_reg;
  wire logic [7:0] ucode_run = ucode_live_reg ? ucode_rev_reg : ucode_saved_reg;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ucode_rev_reg <= 8'h0;
      ucode_live_reg <= 1'b0;
    end else if (dl_ok) begin
      ucode_rev_reg <= ucode_run + 8'h1;
      ucode_live_reg <= 1'b1;
    end
  end

  // saved copy models non-volatile store: no reset term at all
  always_ff @(posedge clk_sys) begin
    if (dl_ok && mode == MODE_DL_SAVE) begin
      ucode_saved_reg <= ucode_run + 8'h1;
    end
  end

  // unit attention per initiator, cleared by software via write-one
  logic aw_hit;
  logic [31:0] wdata_q;
  logic [7:0] awaddr_q;
  logic [3:0] wstrb_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ua_pend_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_INIT; i++) begin
        if (dl_ok && 3'(i) != init_reg) begin
          ua_pend_reg[i] <= 1'b1;
        end else if (aw_hit && awaddr_q == A_UA_PEND && wdata_q[i]) begin
          ua_pend_reg[i] <= 1'b0;
        end
      end
    end
  end

  // axi4-lite write path
  logic aw_held;
  logic w_held;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign aw_hit = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_hit) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q <= A_UCODE_REV && awaddr_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      enable_reg <= 1'b1;
      irq_mask_reg <= IRQ_MASK_RST;
      max_block_reg <= MAX_BLOCK_RST;
    end else if (aw_hit) begin
      if (awaddr_q == A_CTRL && wstrb_q[0]) enable_reg <= wdata_q[0];
      if (awaddr_q == A_IRQ_MASK && wstrb_q[0]) irq_mask_reg <= wdata_q[7:0];
      if (awaddr_q == A_MAX_BLOCK) max_block_reg <= wdata_q;
    end
  end

  // axi4-lite read path
  logic rd_stat_clr;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      rd_stat_clr <= 1'b0;
    end else begin
      rd_stat_clr <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          A_CTRL: s_axi_rdata <= {31'h0, enable_reg};
          A_STATUS: s_axi_rdata <= {24'h0, 5'h0, 3'(state_reg)};
          A_SENSE: s_axi_rdata <= {12'h0, result_reg};
          A_IRQ_STAT: begin
            s_axi_rdata <= {24'h0, irq_stat_reg};
            rd_stat_clr <= 1'b1;
          end
          A_IRQ_MASK: s_axi_rdata <= {24'h0, irq_mask_reg};
          A_MAX_BLOCK: s_axi_rdata <= max_block_reg;
          A_UA_PEND: s_axi_rdata <= 32'(ua_pend_reg);
          A_POS: s_axi_rdata <= pos_reg;
          A_UCODE_REV: s_axi_rdata <= {16'h0, ucode_saved_reg, ucode_run};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // sticky interrupt status: a new event wins over the read clear
  logic [7:0] irq_evt;
  always_comb begin
    irq_evt = 8'h0;
    irq_evt[IRQ_DONE] = cmd_ok_done;
    irq_evt[IRQ_CHECK] = (state_reg == S_DONE) && (result_reg.status == ST_CHECK);
    irq_evt[IRQ_UCODE] = dl_ok;
    irq_evt[IRQ_BYTE] = byte_take;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_reg <= 8'h0;
    end else begin
      irq_stat_reg <= (rd_stat_clr ? 8'h0 : irq_stat_reg) | irq_evt;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // checks
  AST_BAD_ID: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == S_DECODE && cdb_reg.opcode == OP_BUF_WRITE && mode == MODE_DATA && cdb_reg.b2 >= 8'(NUM_BUFS))
    |=> (state_reg == S_DONE && result_reg.asc == ASC_BAD_FIELD && result_reg.sense_key == SK_ILLEGAL))
    else $error("bad buffer id not rejected");
  AST_CAPACITY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == S_DECODE && cdb_reg.opcode == OP_BUF_WRITE && mode == MODE_DATA && end_off > 25'(BUF_DEPTH))
    |=> (result_reg.status == ST_CHECK))
    else $error("overlong data-mode write accepted");
  AST_LEN_BOUND: assert property (@(posedge clk_sys) disable iff (sys_rst)
    byte_take |-> (count_reg < 32'(plen)))
    else $error("byte accepted past parameter list length");
  AST_BAD_BLOCK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == S_DECODE && cdb_reg.opcode == OP_LONG_WRITE && !relative_address_flag && cdb_reg.b6 == 8'h0 &&
     long_len == 16'(PHYS_SECTOR + ECC_BYTES) && start_block > max_block_reg)
    |=> (result_reg.asc == ASC_BAD_BLOCK && state_reg == S_DONE))
    else $error("invalid block not reported");
  AST_POS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (media_req) |-> (media_byte_pos == 32'(start_block * 32'(PHYS_SECTOR))))
    else $error("media position not physical");
  sequence s_dl_done;
    dl_ok;
  endsequence
  AST_UA: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_dl_done |=> (&(ua_pend_reg | (NUM_INIT'(1) << $past(init_reg)))))
    else $error("unit attention wrong after download");
  AST_SAVE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (dl_ok && mode == MODE_DL_SAVE) |=> (ucode_saved_reg == ucode_rev_reg))
    else $error("saved code not updated");
  AST_GOOD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == S_MEDIA && media_done) |=> (done_valid && done_result.status == ST_GOOD) ##1 !done_valid)
    else $error("good status missing");
endmodule : wbl_cmd

// ==== tb/wbl_initiator.sv ====
// initiator model: issues command blocks and supplies data-out bytes at a chosen pace
`timescale 1ns/1ps
module wbl_initiator import wbl_pkg::*; (
  // clock
  input wire logic clk_sys,
  // command
  output logic cmd_valid,
  input wire logic cmd_ready,
  output wbl_cdb_t cmd_cdb,
  output logic [2:0] cmd_initiator,
  // data out
  output logic dout_valid,
  input wire logic dout_ready,
  output logic [7:0] dout_data,
  // completion
  input wire logic done_valid,
  input wire wbl_result_t done_result,
  input wire logic [31:0] xfer_count
);
  initial begin
    cmd_valid = 1'h0;
    cmd_cdb = '0;
    cmd_initiator = 3'h0;
    dout_valid = 1'h0;
    dout_data = 8'h00;
  end

  // offers nb bytes, idling gap cycles after each; a hang returns all ones
  task automatic issue(input wbl_cdb_t cdb, input logic [2:0] who, input int nb, input int gap,
                       output wbl_result_t res, output logic [31:0] cnt);
    int n = 0;
    int g = 0;
    int t = 0;
    bit fin = 0;
    res = '1;
    cnt = '1;
    cmd_valid <= 1'h1;
    cmd_cdb <= cdb;
    cmd_initiator <= who;
    do begin
      @(posedge clk_sys);
      t++;
    end while (!cmd_ready && t < 100);
    cmd_valid <= 1'h0;
    // a released block must not keep looking valid
    cmd_cdb <= wbl_cdb_t'(~cdb);
    while (1) begin
      if (!fin && n < nb && g == 0) begin
        dout_valid <= 1'h1;
        dout_data <= 8'h5a ^ n[7:0];
      end else if (dout_valid) begin
        dout_valid <= 1'h0;
        dout_data <= ~dout_data;
      end
      if (fin || t > 4000) break;
      @(posedge clk_sys);
      t++;
      if (dout_valid && dout_ready) g = gap;
      else if (g > 0) g--;
      if (dout_valid && dout_ready) n++;
      if (done_valid) begin
        fin = 1;
        res = done_result;
        cnt = xfer_count;
      end
    end
  endtask : issue
endmodule : wbl_initiator

// ==== tb/wbl_cmd_bench.sv ====
// testbench for the buffer-write / long-write command block
`timescale 1ns/1ps
module wbl_cmd_bench import wbl_pkg::*;;
  localparam wbl_result_t GOOD = {ST_GOOD, SK_NONE, ASC_NONE};
  localparam wbl_result_t FLD = {ST_CHECK, SK_ILLEGAL, ASC_BAD_FIELD};
  localparam wbl_result_t BLK = {ST_CHECK, SK_ILLEGAL, ASC_BAD_BLOCK};
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic cmd_valid, cmd_ready, dout_valid, dout_ready, done_valid, media_req, irq;
  logic media_done = 1'h0;
  wbl_cdb_t cmd_cdb;
  logic [2:0] cmd_initiator;
  logic [7:0] dout_data;
  wbl_result_t done_result;
  logic [31:0] xfer_count, media_byte_pos, mpos;
  logic [15:0] media_len, mlen;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mcnt = 0;
  int err_total = 0;
  int n_tests = 0;

  always #12.5 clk_sys = ~clk_sys;

  wbl_cmd #(.NUM_BUFS(2), .BUF_DEPTH(256), .OFFSET_ALIGN(1), .PHYS_SECTOR(512), .NUM_INIT(8)) u_dut (
    .clk_sys, .sys_rst, .cmd_valid, .cmd_ready, .cmd_cdb, .cmd_initiator, .dout_valid, .dout_ready,
    .dout_data, .done_valid, .done_result, .xfer_count, .media_req, .media_byte_pos, .media_len,
    .media_done, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

  wbl_initiator u_init (
    .clk_sys, .cmd_valid, .cmd_ready, .cmd_cdb, .cmd_initiator, .dout_valid, .dout_ready,
    .dout_data, .done_valid, .done_result, .xfer_count);

  // media side answers each write request four cycles after it is raised
  always @(posedge clk_sys) begin
    media_done <= media_req && !media_done && mcnt == 3;
    mcnt <= (media_req && !media_done && mcnt < 3) ? mcnt + 1 : 0;
    if (media_req) begin
      mpos <= media_byte_pos;
      mlen <= media_len;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    int t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      t++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && t < 50);
    check("bresp", 32'({t >= 50, s_axi_bresp}), 32'(RESP_OKAY));
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      t++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && t < 50);
    d = s_axi_rdata;
    r = (t >= 50) ? 2'h3 : s_axi_rresp;
  endtask : axi_rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check("register", d, exp);
  endtask : rchk

  function automatic wbl_cdb_t bw(logic [2:0] m, logic [7:0] id, logic [23:0] off, logic [23:0] len);
    return {OP_BUF_WRITE, 5'h00, m, id, off, len, 8'h00};
  endfunction : bw

  function automatic wbl_cdb_t lw(logic rel, logic [31:0] blk, logic [7:0] b6, logic [15:0] len);
    return {OP_LONG_WRITE, 7'h00, rel, blk, b6, len, 8'h00};
  endfunction : lw

  task automatic run(input wbl_cdb_t c, input logic [2:0] who, input int nb, input wbl_result_t exp,
                     input logic [31:0] ecnt);
    wbl_result_t r;
    logic [31:0] n;
    u_init.issue(c, who, nb, nb % 3, r, n);
    check("result", 32'(r), 32'(exp));
    if (exp == GOOD) check("count", n, ecnt);
  endtask : run

  task automatic rst();
    sys_rst <= 1'h1;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(posedge clk_sys);
  endtask : rst

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // whole run needs about 2500 cycles; over thirty times that means a hang
  initial begin
    #2ms;
    err_total++;
    end_of_test();
  end

  initial begin
    logic [31:0] r0, r1, r2, r3;
    logic [1:0] rs;
    rst();
    rchk(A_CTRL, 32'h1);
    rchk(A_IRQ_MASK, 32'h0);
    rchk(A_MAX_BLOCK, 32'h0000ffff);
    axi_rd(8'h40, r0, rs);
    check("unmapped", r0, 32'h0);
    check("unmapped_resp", 32'(rs), 32'(RESP_SLVERR));
    axi_wr(A_CTRL, 32'h0);
    check("ready_off", 32'(cmd_ready), 32'h0);
    axi_wr(A_CTRL, 32'h1);
    axi_wr(A_CTRL, 32'h0, 4'h0);
    check("ready_strb", 32'(cmd_ready), 32'h1);
    run(bw(MODE_DATA, 8'h00, 24'h00000a, 24'h000014), 3'h1, 25, GOOD, 32'h14);
    run(bw(MODE_DATA, 8'h01, 24'h0000fa, 24'h000006), 3'h1, 6, GOOD, 32'h6);
    run(bw(MODE_DATA, 8'h02, 24'h0, 24'h4), 3'h1, 4, FLD, 32'h0);
    run(bw(MODE_DATA, 8'h00, 24'h000100, 24'h1), 3'h1, 1, FLD, 32'h0);
    run(bw(MODE_DATA, 8'h00, 24'h0000fa, 24'h7), 3'h1, 7, FLD, 32'h0);
    run(bw(3'h3, 8'h00, 24'h0, 24'h4), 3'h1, 4, FLD, 32'h0);
    run(bw(MODE_DATA, 8'h00, 24'h0, 24'h0), 3'h1, 4, GOOD, 32'h0);
    axi_rd(A_UCODE_REV, r0, rs);
    run(bw(MODE_DL, 8'h07, 24'h123456, 24'h10), 3'h2, 16, GOOD, 32'h10);
    rchk(A_UA_PEND, 32'hfb);
    axi_wr(A_UA_PEND, 32'hff);
    rchk(A_UA_PEND, 32'h0);
    axi_rd(A_UCODE_REV, r1, rs);
    check("rev_load", 32'(r1 !== r0), 32'h1);
    run(bw(MODE_DL_SAVE, 8'h00, 24'h0, 24'h8), 3'h0, 8, GOOD, 32'h8);
    axi_rd(A_UCODE_REV, r2, rs);
    check("rev_save", 32'(r2 !== r1), 32'h1);
    rst();
    rchk(A_UCODE_REV, r2);
    run(bw(MODE_DL, 8'h00, 24'h0, 24'h8), 3'h5, 8, GOOD, 32'h8);
    axi_rd(A_UCODE_REV, r3, rs);
    check("rev_again", 32'(r3 !== r2), 32'h1);
    rst();
    rchk(A_UCODE_REV, r2);
    run(lw(1'h0, 32'h10, 8'h00, 16'h020b), 3'h1, 523, GOOD, 32'h20b);
    check("media_pos", mpos, 32'h2000);
    check("media_len", mlen, 32'h20b);
    run(lw(1'h0, 32'hffff, 8'h00, 16'h020b), 3'h1, 523, GOOD, 32'h20b);
    check("media_pos", mpos, 32'h01fffe00);
    run(lw(1'h0, 32'h10000, 8'h00, 16'h020b), 3'h1, 523, BLK, 32'h0);
    run(lw(1'h1, 32'h10, 8'h00, 16'h020b), 3'h1, 523, FLD, 32'h0);
    run(lw(1'h0, 32'h10, 8'h01, 16'h020b), 3'h1, 523, FLD, 32'h0);
    run(lw(1'h0, 32'h10, 8'h00, 16'h0207), 3'h1, 519, FLD, 32'h0);
    axi_wr(A_MAX_BLOCK, 32'h20);
    run(lw(1'h0, 32'h21, 8'h00, 16'h020b), 3'h1, 523, BLK, 32'h0);
    axi_rd(A_IRQ_STAT, r0, rs);
    axi_wr(A_IRQ_MASK, 32'h2);
    run(bw(MODE_DATA, 8'h00, 24'h0, 24'h0), 3'h1, 0, GOOD, 32'h0);
    @(posedge clk_sys);
    check("irq_masked", 32'(irq), 32'h0);
    run(bw(MODE_DATA, 8'h05, 24'h0, 24'h4), 3'h1, 4, FLD, 32'h0);
    @(posedge clk_sys);
    check("irq_raised", 32'(irq), 32'h1);
    rchk(A_IRQ_STAT, 32'h3);
    @(posedge clk_sys);
    check("irq_cleared", 32'(irq), 32'h0);
    end_of_test();
  end
endmodule : wbl_cmd_bench
